// *** hdl/ufc_params.svh ***
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// Register byte offsets
`define UFC_A_DIV_LO 8'h00
`define UFC_A_DIV_HI 8'h04
`define UFC_A_IER 8'h08
`define UFC_A_FCR 8'h0c
`define UFC_A_LCR 8'h10
`define UFC_A_MCR 8'h14
`define UFC_A_LSR 8'h18
`define UFC_A_MSR 8'h1c
`define UFC_A_SPR 8'h20
`define UFC_A_EFR 8'h24
`define UFC_A_TCR 8'h28
`define UFC_A_TLR 8'h2c
`define UFC_A_R1 8'h30
`define UFC_A_R2 8'h34
`define UFC_A_P1 8'h38
`define UFC_A_P2 8'h3c
`define UFC_A_IIR 8'h40
`define UFC_A_LVL 8'h44
`define UFC_A_IOC 8'h48
`define UFC_A_SWRST 8'h4c
// Reset and identification values
`define UFC_RST_LCR 8'h1d
`define UFC_RST_LSR 8'h60
`define UFC_RST_TXLVL 8'h40
`define UFC_RST_IIR 8'h01
`define UFC_IIR_PAUSE 8'h10
// Trigger levels in characters
`define UFC_TRIG_OFF 7'h01
`define UFC_TRIG_0 7'h08
`define UFC_TRIG_1 7'h10
`define UFC_TRIG_2 7'h20
`define UFC_TRIG_3 7'h38
// Word length masks
`define UFC_MASK_5 8'h1f
`define UFC_MASK_6 8'h3f
`define UFC_MASK_7 8'h7f
`define UFC_MASK_8 8'hff
// Field positions
`define UFC_EFR_ACTS 7
`define UFC_EFR_ARTS 6
`define UFC_EFR_SPEC 5
`define UFC_MCR_ANY 5
`define UFC_MCR_RTS 1
`define UFC_IER_PAUSE 5
`define UFC_FCR_EN 0
`define UFC_SWRST_BIT 0
`endif

// *** hdl/ufc_pkg.sv ***
// Purpose: types of the flow control block
// Assumes: ufc_params.svh holds the numbers
// Notes: cleared state is one packed struct, values kept across reset another
package ufc_pkg;
  typedef enum logic [1:0] {UFC_RUN = 2'b01, UFC_HALT = 2'b10} ufc_flow_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufc_char_t;
  typedef struct packed {
    logic [7:0] irq_enable_reg, fifo_ctrl_reg, line_ctrl_reg, modem_ctrl_reg, enhanced_feature_reg, flow_threshold_reg, programmable_trigger_reg, ioc, line_status_reg, tx_lvl, rx_lvl;
    logic msr_d, cts_s1, cts_s2, cts_prev;
    ufc_flow_t rts_st, sw_st;
    logic [1:0] pend;
    logic pend_res, paused, prev_p1, prev_r1, pause_flag, spec_flag;
    logic rts_n, irq_oe, pop, fifo_clr;
    logic [6:0] rx_trig, tx_trig;
    ufc_char_t tx, rx_st;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } ufc_state_t;
  typedef struct packed {
    logic [7:0] div_lo, div_hi, scratchpad_reg, r1, r2, p1, p2;
  } ufc_keep_t;
endpackage : ufc_pkg

// *** hdl/ufc_top.sv ***
// Purpose: UART flow control and FIFO trigger logic behind AHB-Lite
// Assumes: transmitter, receiver and FIFOs sit outside on hclk
// Notes: divisor, scratchpad and flow characters survive reset
// Functional notes
// - FIFOs off after reset, trigger one
// - nonzero programmable trigger wins, else selectable
// - auto CTS and auto RTS enabled separately
// - auto CTS sampled before each character start
// - RTS active below halt, dropped at halt
// - RTS reasserted at resume threshold
// - zero threshold register uses selectable triggers
// - late character after RTS drop still stored
// - upper field bits pick transmitted flow sets
// - lower field bits pick receive comparison
// - resume-on-any restarts transmit after pause
// - special character flags, stores, never halts
// - pause stops after current character, flags
// - resume character restarts, clears pause flag
// - pause characters sent past halt level
// - resume characters sent at resume level, below it with selectable triggers
// - flow characters masked to word length
// - all resets give same register values
// - divisor, scratchpad, flow characters not reset
// - RTS high, IRQ released, modem status
// - RTS and CTS active low
//
// The register addresses and register access over AHB-Lite were decided locally.
`include "ufc_params.svh"
module ufc_top (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Modem and interrupt pins
  input wire logic cts_n,
  output logic rts_n,
  output logic irq_n_o,
  output logic irq_n_oe,
  // Receiver and receive FIFO
  input wire ufc_pkg::ufc_char_t rx_in,
  input wire logic [6:0] rx_level,
  output ufc_pkg::ufc_char_t rx_store,
  output logic [6:0] rx_trig_level,
  // Transmitter and transmit FIFO
  input wire logic tx_ready,
  input wire logic tx_data_valid,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] tx_space,
  output ufc_pkg::ufc_char_t tx_out,
  output logic tx_data_pop,
  output logic [6:0] tx_trig_level,
  // Configuration to the rest of the UART
  output logic fifo_clear,
  output logic [15:0] divisor,
  output logic [7:0] line_ctrl,
  output logic [7:0] io_ctrl
);
  ufc_pkg::ufc_state_t st, n;
  ufc_pkg::ufc_keep_t kp, nk;
  logic [6:0] rx_trig, tx_trig, halt_lvl, res_lvl;
  logic [7:0] wmask, rc, rd, flow_char;
  logic tcr_used, either, seq, cts_ok, ap, sw_res;
  logic m_p1, m_p2, m_r1, m_r2;
  logic spec_hit, pause_hit, resume_hit, first_hit, any_hit, consumed;

  // Reset image of all cleared state
  function automatic ufc_pkg::ufc_state_t rst_val();
    ufc_pkg::ufc_state_t r;
    r = '0;
    r.line_ctrl_reg = `UFC_RST_LCR;
    r.line_status_reg = `UFC_RST_LSR;
    r.tx_lvl = `UFC_RST_TXLVL;
    r.rts_st = ufc_pkg::UFC_RUN;
    r.sw_st = ufc_pkg::UFC_RUN;
    r.rts_n = 1'b1;
    r.rx_trig = `UFC_TRIG_OFF;
    r.tx_trig = `UFC_TRIG_OFF;
    return r;
  endfunction : rst_val

  localparam ufc_pkg::ufc_state_t ST_RST = rst_val();

  // Selectable trigger level by index
  function automatic logic [6:0] sel_lvl(input logic [1:0] i);
    case (i)
      2'h0: sel_lvl = `UFC_TRIG_0;
      2'h1: sel_lvl = `UFC_TRIG_1;
      2'h2: sel_lvl = `UFC_TRIG_2;
      default: sel_lvl = `UFC_TRIG_3;
    endcase
  endfunction : sel_lvl

  // Trigger levels: FIFO off gives one, programmable beats selectable
  assign rx_trig = !st.fifo_ctrl_reg[`UFC_FCR_EN] ? `UFC_TRIG_OFF :
                   (st.programmable_trigger_reg[7:4] != 4'h0) ? {1'b0, st.programmable_trigger_reg[7:4], 2'b00} :
                   sel_lvl(st.fifo_ctrl_reg[7:6]);
  assign tx_trig = !st.fifo_ctrl_reg[`UFC_FCR_EN] ? `UFC_TRIG_OFF :
                   (st.programmable_trigger_reg[3:0] != 4'h0) ? {1'b0, st.programmable_trigger_reg[3:0], 2'b00} :
                   sel_lvl(st.fifo_ctrl_reg[5:4]);

  // Halt and resume points
  assign tcr_used = st.flow_threshold_reg != 8'h00;
  assign halt_lvl = tcr_used ? {1'b0, st.flow_threshold_reg[3:0], 2'b00} : rx_trig;
  assign res_lvl = tcr_used ? {1'b0, st.flow_threshold_reg[7:4], 2'b00} :
                   (st.fifo_ctrl_reg[7:6] == 2'h0) ? 7'h00 : sel_lvl(st.fifo_ctrl_reg[7:6] - 2'h1);
  assign sw_res = tcr_used ? (rx_level <= res_lvl) : (rx_level < res_lvl);

  // Word length mask
  always_comb begin
    case (st.line_ctrl_reg[1:0])
      2'h0: wmask = `UFC_MASK_5;
      2'h1: wmask = `UFC_MASK_6;
      2'h2: wmask = `UFC_MASK_7;
      default: wmask = `UFC_MASK_8;
    endcase
  end

  // Received character against the four flow characters
  assign rc = rx_in.data & wmask;
  assign m_p1 = rc == (kp.p1 & wmask);
  assign m_p2 = rc == (kp.p2 & wmask);
  assign m_r1 = rc == (kp.r1 & wmask);
  assign m_r2 = rc == (kp.r2 & wmask);

  // Receive comparison modes
  assign either = (st.enhanced_feature_reg[1:0] == 2'b11) && (st.enhanced_feature_reg[3:2] == 2'b10 || st.enhanced_feature_reg[3:2] == 2'b01);
  assign seq = (st.enhanced_feature_reg[1:0] == 2'b11) && !either;
  assign spec_hit = rx_in.valid && st.enhanced_feature_reg[`UFC_EFR_SPEC] && m_p2;
  always_comb begin
    pause_hit = 1'b0;
    resume_hit = 1'b0;
    if (rx_in.valid && !spec_hit) begin
      if (st.enhanced_feature_reg[1:0] == 2'b10) begin
        pause_hit = m_p1;
        resume_hit = m_r1;
      end else if (st.enhanced_feature_reg[1:0] == 2'b01) begin
        pause_hit = m_p2;
        resume_hit = m_r2;
      end else if (either) begin
        pause_hit = m_p1 || m_p2;
        resume_hit = m_r1 || m_r2;
      end else if (seq) begin
        pause_hit = st.prev_p1 && m_p2;
        resume_hit = st.prev_r1 && m_r2;
      end
    end
  end
  assign first_hit = rx_in.valid && seq && !spec_hit && !pause_hit && !resume_hit && (m_p1 || m_r1);
  assign any_hit = rx_in.valid && st.modem_ctrl_reg[`UFC_MCR_ANY] && st.paused && !pause_hit;
  assign consumed = pause_hit || resume_hit || first_hit;

  // Auto CTS gate, CTS low permits a start
  assign cts_ok = !st.enhanced_feature_reg[`UFC_EFR_ACTS] || !st.cts_s2;

  // Flow character chosen from the pending set
  assign flow_char = (st.pend_res ? (st.pend[0] ? kp.r1 : kp.r2) : (st.pend[0] ? kp.p1 : kp.p2)) & wmask;

  // Bus address phase
  assign ap = hsel && htrans[1] && hready;

  // Next state of the whole block
  always_comb begin
    n = st;
    nk = kp;
    rd = 8'h00;
    n.tx.valid = 1'b0;
    n.pop = 1'b0;
    n.rx_st.valid = 1'b0;
    n.fifo_clr = 1'b0;
    n.cts_s1 = cts_n;
    n.cts_s2 = st.cts_s1;
    n.cts_prev = st.cts_s2;
    n.line_status_reg = {1'b0, tx_ready && !tx_data_valid, !tx_data_valid, 5'h00};
    n.tx_lvl = tx_space;
    n.rx_lvl = {1'b0, rx_level};
    n.rx_trig = rx_trig;
    n.tx_trig = tx_trig;
    if (st.cts_s2 != st.cts_prev) begin
      n.msr_d = 1'b1;
    end
    // Hardware flow hysteresis
    case (st.rts_st)
      ufc_pkg::UFC_RUN: begin
        if (rx_level >= halt_lvl) begin
          n.rts_st = ufc_pkg::UFC_HALT;
        end
      end
      ufc_pkg::UFC_HALT: begin
        if (rx_level <= res_lvl) begin
          n.rts_st = ufc_pkg::UFC_RUN;
        end
      end
      default: n.rts_st = ufc_pkg::UFC_RUN;
    endcase
    // Transmitter arbitration, flow characters first
    if (tx_ready && cts_ok && !st.tx.valid) begin
      if (st.pend != 2'b00) begin
        n.tx = '{1'b1, flow_char};
        if (st.pend[0]) begin
          n.pend[0] = 1'b0;
        end else begin
          n.pend[1] = 1'b0;
        end
      end else if (tx_data_valid && !st.paused) begin
        n.tx = '{1'b1, tx_data & wmask};
        n.pop = 1'b1;
      end
    end
    // Software flow hysteresis, queues the chosen sets
    case (st.sw_st)
      ufc_pkg::UFC_RUN: begin
        if (rx_level > halt_lvl) begin
          n.sw_st = ufc_pkg::UFC_HALT;
          n.pend = {st.enhanced_feature_reg[2], st.enhanced_feature_reg[3]};
          n.pend_res = 1'b0;
        end
      end
      ufc_pkg::UFC_HALT: begin
        if (sw_res) begin
          n.sw_st = ufc_pkg::UFC_RUN;
          n.pend = {st.enhanced_feature_reg[2], st.enhanced_feature_reg[3]};
          n.pend_res = 1'b1;
        end
      end
      default: n.sw_st = ufc_pkg::UFC_RUN;
    endcase
    // Received flow characters
    if (rx_in.valid) begin
      n.prev_p1 = first_hit && m_p1;
      n.prev_r1 = first_hit && m_r1;
    end
    if (pause_hit) begin
      n.paused = 1'b1;
      if (st.irq_enable_reg[`UFC_IER_PAUSE]) begin
        n.pause_flag = 1'b1;
      end
    end
    if (resume_hit || any_hit) begin
      n.paused = 1'b0;
      n.pause_flag = 1'b0;
    end
    if (rx_in.valid && !consumed) begin
      n.rx_st = '{1'b1, rx_in.data};
    end
    // Data phase write
    if (st.dp_wr) begin
      case (st.dp_addr)
        `UFC_A_DIV_LO: nk.div_lo = hwdata[7:0];
        `UFC_A_DIV_HI: nk.div_hi = hwdata[7:0];
        `UFC_A_IER: n.irq_enable_reg = hwdata[7:0];
        `UFC_A_FCR: n.fifo_ctrl_reg = hwdata[7:0];
        `UFC_A_LCR: n.line_ctrl_reg = hwdata[7:0];
        `UFC_A_MCR: n.modem_ctrl_reg = hwdata[7:0];
        `UFC_A_SPR: nk.scratchpad_reg = hwdata[7:0];
        `UFC_A_EFR: n.enhanced_feature_reg = hwdata[7:0];
        `UFC_A_TCR: n.flow_threshold_reg = hwdata[7:0];
        `UFC_A_TLR: n.programmable_trigger_reg = hwdata[7:0];
        `UFC_A_R1: nk.r1 = hwdata[7:0];
        `UFC_A_R2: nk.r2 = hwdata[7:0];
        `UFC_A_P1: nk.p1 = hwdata[7:0];
        `UFC_A_P2: nk.p2 = hwdata[7:0];
        `UFC_A_IOC: n.ioc = hwdata[7:0];
        `UFC_A_SWRST: begin
          if (hwdata[`UFC_SWRST_BIT]) begin
            n = ST_RST;
            n.cts_s1 = cts_n;
            n.cts_s2 = st.cts_s1;
            n.cts_prev = st.cts_s2;
            n.fifo_clr = 1'b1;
          end
        end
        default: n.irq_enable_reg = n.irq_enable_reg;
      endcase
    end
    // Address phase capture and read data
    n.dp_wr = ap && hwrite;
    n.dp_addr = haddr[7:0];
    if (ap && !hwrite) begin
      case (haddr[7:0])
        `UFC_A_DIV_LO: rd = nk.div_lo;
        `UFC_A_DIV_HI: rd = nk.div_hi;
        `UFC_A_IER: rd = n.irq_enable_reg;
        `UFC_A_FCR: rd = n.fifo_ctrl_reg;
        `UFC_A_LCR: rd = n.line_ctrl_reg;
        `UFC_A_MCR: rd = n.modem_ctrl_reg;
        `UFC_A_LSR: rd = n.line_status_reg;
        `UFC_A_MSR: rd = {3'b000, !st.cts_s2, 3'b000, n.msr_d};
        `UFC_A_SPR: rd = nk.scratchpad_reg;
        `UFC_A_EFR: rd = n.enhanced_feature_reg;
        `UFC_A_TCR: rd = n.flow_threshold_reg;
        `UFC_A_TLR: rd = n.programmable_trigger_reg;
        `UFC_A_R1: rd = nk.r1;
        `UFC_A_R2: rd = nk.r2;
        `UFC_A_P1: rd = nk.p1;
        `UFC_A_P2: rd = nk.p2;
        `UFC_A_IIR: rd = (n.pause_flag || n.spec_flag) ? `UFC_IIR_PAUSE : `UFC_RST_IIR;
        `UFC_A_LVL: rd = n.tx_lvl;
        `UFC_A_IOC: rd = n.ioc;
        default: rd = 8'h00;
      endcase
      n.hrdata = {24'h000000, rd};
      // Reads that clear, a new event in the same cycle wins
      if (haddr[7:0] == `UFC_A_MSR && st.cts_s2 == st.cts_prev) begin
        n.msr_d = 1'b0;
      end
      if (haddr[7:0] == `UFC_A_IIR && !spec_hit) begin
        n.spec_flag = 1'b0;
      end
    end
    if (spec_hit) begin
      n.spec_flag = 1'b1;
    end
    // Pin drive from the settled next state
    n.rts_n = n.enhanced_feature_reg[`UFC_EFR_ARTS] ? (n.rts_st == ufc_pkg::UFC_HALT) : !n.modem_ctrl_reg[`UFC_MCR_RTS];
    n.irq_oe = n.pause_flag || n.spec_flag;
  end

  // State register, cleared by the reset pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= n;
    end
  end

  // Values kept across every reset
  always_ff @(posedge hclk) begin
    if (ce) begin
      kp <= nk;
    end
  end

  // Outputs
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rts_n = st.rts_n;
  assign irq_n_o = 1'b0;
  assign irq_n_oe = st.irq_oe;
  assign rx_store = st.rx_st;
  assign rx_trig_level = st.rx_trig;
  assign tx_out = st.tx;
  assign tx_data_pop = st.pop;
  assign tx_trig_level = st.tx_trig;
  assign fifo_clear = st.fifo_clr;
  assign divisor = {kp.div_hi, kp.div_lo};
  assign line_ctrl = st.line_ctrl_reg;
  assign io_ctrl = st.ioc;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_trig_off: assert property ((ce && !st.fifo_ctrl_reg[0]) |=> rx_trig_level == 7'h01)
    else $error("trigger not one with FIFO off");
  chk_trig_prog: assert property ((ce && st.fifo_ctrl_reg[0] && st.programmable_trigger_reg[7:4] != 4'h0)
    |=> rx_trig_level == {1'b0, $past(st.programmable_trigger_reg[7:4]), 2'b00})
    else $error("programmable trigger ignored");
  chk_rts_manual: assert property ((ce && !st.enhanced_feature_reg[6] && !st.dp_wr) |=> rts_n == !$past(st.modem_ctrl_reg[1]))
    else $error("manual RTS wrong");
  chk_cts_gate: assert property (tx_out.valid |-> (!$past(st.enhanced_feature_reg[7]) || !$past(st.cts_s2)))
    else $error("start while CTS inactive");
  chk_rts_halt: assert property ((ce && st.enhanced_feature_reg[6] && !st.dp_wr && st.rts_st == ufc_pkg::UFC_RUN
    && rx_level >= halt_lvl) |=> rts_n)
    else $error("RTS not dropped at halt");
  chk_rts_resume: assert property ((ce && st.enhanced_feature_reg[6] && !st.dp_wr && st.rts_st == ufc_pkg::UFC_HALT
    && rx_level <= res_lvl) |=> !rts_n)
    else $error("RTS not resumed");
  chk_rx_store: assert property ((ce && rx_in.valid && !consumed)
    |=> rx_store.valid && rx_store.data == $past(rx_in.data))
    else $error("character not stored");
  chk_pause_hold: assert property (st.paused |=> !tx_data_pop)
    else $error("data sent while paused");
  chk_resume_clear: assert property ((ce && resume_hit && !st.dp_wr) |=> !st.paused && !st.pause_flag)
    else $error("resume did not clear");
  chk_special_char: assert property ((ce && spec_hit && !st.paused && !st.dp_wr)
    |=> !st.paused && st.spec_flag && rx_store.valid)
    else $error("special character mishandled");
  chk_flow_mask: assert property ((tx_out.valid && $past(st.line_ctrl_reg[1:0]) == 2'b00) |-> tx_out.data[7:5] == 3'b000)
    else $error("flow character not masked");
  chk_reset_vals: assert property ($rose(hresetn) |-> st.line_ctrl_reg == 8'h1d && rts_n && !irq_n_oe)
    else $error("reset values wrong");

  cov_pause: cover property (ce && pause_hit);
  cov_resume: cover property (ce && resume_hit);
  cov_special: cover property (ce && spec_hit);
  cov_flow_tx: cover property (tx_out.valid && !tx_data_pop);
  cov_rts_cycle: cover property (rts_n ##1 !rts_n);
endmodule : ufc_top

// *** tb/ufc_peer.sv ***
// Purpose: serial peer model on the far side of the flow control block
// Assumes: one character time of busy line after each start, CTS set on request
// Notes: a released receive line shows the inverse of the last character
module ufc_peer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Transmit side of the device
  input wire ufc_pkg::ufc_char_t tx_out,
  output logic tx_ready,
  output logic cts_n,
  // Receive side of the device
  output ufc_pkg::ufc_char_t rx_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy;
  int char_time = 2;
  logic cts_req = 1'b0;
  initial rx_in = '0;
  // Line busy for one character time after each start; CTS follows the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready <= 1'b1;
      busy <= 0;
      cts_n <= 1'b0;
    end else begin
      cts_n <= cts_req;
      if (tx_out.valid) begin
        tx_ready <= 1'b0;
        busy <= char_time;
      end else if (busy > 1) begin
        busy <= busy - 1;
      end else begin
        tx_ready <= 1'b1;
      end
    end
  end
  // One received character, then the released line
  task send(input logic [7:0] d);
    @(posedge hclk);
    rx_in <= '{valid: 1'b1, data: d};
    @(posedge hclk);
    rx_in <= '{valid: 1'b0, data: ~d};
  endtask : send
endmodule : ufc_peer

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the flow control block
// Assumes: bench is the AHB-Lite master, peer model on the serial side
// Notes: drivers queue expectations, monitors compare the oldest one
`include "ufc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hready, tx_data_valid;
  logic hreadyout, hresp, cts_n, rts_n, irq_n_o, irq_n_oe, tx_ready, tx_data_pop, fifo_clear;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] rx_level, rx_trig_level, tx_trig_level;
  logic [7:0] tx_data, tx_space, line_ctrl, io_ctrl;
  logic [15:0] divisor;
  ufc_pkg::ufc_char_t rx_in, rx_store, tx_out;
  logic [31:0] q_rd[$], q_tx[$], q_rx[$];
  logic [7:0] ch[4];
  int n_mismatch, n_compared, n_clr;
  event rd_ev;
  assign hready = hreadyout;
  ufc_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cts_n(cts_n), .rts_n(rts_n), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .rx_in(rx_in), .rx_level(rx_level), .rx_store(rx_store),
    .rx_trig_level(rx_trig_level), .tx_ready(tx_ready), .tx_data_valid(tx_data_valid),
    .tx_data(tx_data), .tx_space(tx_space), .tx_out(tx_out), .tx_data_pop(tx_data_pop),
    .tx_trig_level(tx_trig_level), .fifo_clear(fifo_clear), .divisor(divisor),
    .line_ctrl(line_ctrl), .io_ctrl(io_ctrl));
  ufc_peer peer (.hclk(hclk), .hresetn(hresetn), .tx_out(tx_out), .tx_ready(tx_ready), .cts_n(cts_n),
    .rx_in(rx_in));
  // Clock of 5 ns
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  // One AHB-Lite single word transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    if (!w) begin
      rd_val = hrdata;
      ->rd_ev;
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic tx_put(input logic [7:0] d);
    tx_data <= d;
    tx_data_valid <= 1'b1;
  endtask : tx_put
  // Bounded wait for the FIFO character to be taken
  task automatic wait_pop;
    repeat (300) begin
      @(posedge hclk);
      if (tx_data_pop === 1'b1) break;
    end
    tx_data_valid <= 1'b0;
  endtask : wait_pop
  task automatic rx_one(input logic [7:0] d);
    q_rx.push_back({24'h0, d});
    peer.send(d);
  endtask : rx_one
  task automatic test_done;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Result monitors: reads, transmit starts, stored characters, clear pulses
  always @(rd_ev) cmp(rd_val, q_rd.pop_front());
  always @(posedge hclk) begin
    if (tx_out.valid === 1'b1) cmp({24'h0, tx_out.data}, q_tx.size() ? q_tx.pop_front() : 32'h1ff);
    if (rx_store.valid === 1'b1) cmp({24'h0, rx_store.data}, q_rx.size() ? q_rx.pop_front() : 32'h1ff);
    if (fifo_clear === 1'b1) n_clr++;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    int lv[2][4];
    logic [7:0] sp;
    lv = '{'{39, 40, 20, 12}, '{31, 32, 17, 16}};
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, tx_data_valid, tx_data, rx_level} = '0;
    hsize = 3'b010;
    tx_space = 8'h40;
    void'($urandom(85));
    sp = 8'($urandom);
    tick(10);
    hresetn <= 1'b1;
    tick(1);
    cmp(rts_n, 1'b1);
    cmp(irq_n_oe, 1'b0);
    cmp(rx_trig_level, `UFC_TRIG_OFF);
    cmp(tx_trig_level, `UFC_TRIG_OFF);
    cmp(hresp, 1'b0);
    cmp(line_ctrl, `UFC_RST_LCR);
    rd(`UFC_A_LCR, `UFC_RST_LCR);
    rd(`UFC_A_LSR, `UFC_RST_LSR);
    rd(`UFC_A_IIR, `UFC_RST_IIR);
    rd(`UFC_A_LVL, `UFC_RST_TXLVL);
    rd(8'h80, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ch[k] = 8'h80 | (8'($urandom) & 8'h3c) | 8'(k);
      wr(`UFC_A_R1 + 8'(4 * k), ch[k]);
    end
    wr(`UFC_A_SPR, sp);
    wr(`UFC_A_DIV_LO, ~sp);
    wr(`UFC_A_IOC, sp);
    tx_space <= 8'($urandom_range(64));
    wr(`UFC_A_LCR, 8'h03);
    rd(`UFC_A_LVL, {24'h0, tx_space});
    // Trigger selection
    wr(`UFC_A_FCR, 8'hc1);
    tick(3);
    cmp(rx_trig_level, `UFC_TRIG_3);
    cmp(tx_trig_level, `UFC_TRIG_0);
    cmp(io_ctrl, sp);
    cmp(line_ctrl, 8'h03);
    wr(`UFC_A_TLR, 8'h55);
    tick(3);
    cmp(rx_trig_level, 7'd20);
    cmp(tx_trig_level, 7'd20);
    wr(`UFC_A_TLR, 8'h00);
    // Auto RTS with threshold register, then with selectable levels
    wr(`UFC_A_EFR, 8'h40);
    for (int j = 0; j < 2; j++) begin
      wr(`UFC_A_TCR, j ? 8'h00 : 8'h3a);
      wr(`UFC_A_FCR, 8'h81);
      for (int k = 0; k < 4; k++) begin
        rx_level <= 7'(lv[j][k]);
        tick(4);
        cmp(rts_n, k == 1 || k == 2);
        if (k == 1) rx_one(8'h41);
      end
    end
    rx_level <= 7'h00;
    // Auto CTS holds the start until permitted, slow peer back to back
    wr(`UFC_A_EFR, 8'h80);
    peer.cts_req <= 1'b1;
    peer.char_time = 12;
    tick(4);
    tx_put(8'($urandom));
    tick(20);
    q_tx.push_back({24'h0, tx_data});
    peer.cts_req <= 1'b0;
    wait_pop();
    for (int k = 0; k < 3; k++) begin
      tick(1);
      tx_put(8'($urandom));
      tick(1);
      q_tx.push_back({24'h0, tx_data});
      wait_pop();
    end
    peer.char_time = 2;
    // Receive pause and resume sets: one, two, both in sequence
    wr(`UFC_A_IER, 8'h20);
    for (int j = 0; j < 3; j++) begin
      wr(`UFC_A_EFR, j == 0 ? 8'h02 : (j == 1 ? 8'h01 : 8'h03));
      for (int k = 0; k <= j / 2; k++) peer.send(ch[2 + j % 2 + k]);
      tick(3);
      cmp(irq_n_oe, 1'b1);
      cmp(irq_n_o, 1'b0);
      rd(`UFC_A_IIR, `UFC_IIR_PAUSE);
      tx_put(8'($urandom));
      tick(20);
      q_tx.push_back({24'h0, tx_data});
      for (int k = 0; k <= j / 2; k++) peer.send(ch[j % 2 + k]);
      wait_pop();
      cmp(irq_n_oe, 1'b0);
      rd(`UFC_A_IIR, `UFC_RST_IIR);
    end
    // Resume on any character
    wr(`UFC_A_EFR, 8'h02);
    wr(`UFC_A_MCR, 8'h20);
    peer.send(ch[2]);
    tx_put(8'($urandom));
    tick(20);
    q_tx.push_back({24'h0, tx_data});
    rx_one(8'h41);
    wait_pop();
    wr(`UFC_A_MCR, 8'h00);
    // Special character flags and stores but does not halt
    wr(`UFC_A_EFR, 8'h20);
    rx_one(ch[3]);
    tick(3);
    tx_put(8'($urandom));
    tick(1);
    q_tx.push_back({24'h0, tx_data});
    wait_pop();
    rd(`UFC_A_IIR, `UFC_IIR_PAUSE);
    rd(`UFC_A_IIR, `UFC_RST_IIR);
    // Transmitted flow characters in 5 bit words: set one, set two, both
    wr(`UFC_A_LCR, 8'h00);
    wr(`UFC_A_TCR, 8'h3a);
    for (int j = 0; j < 3; j++) begin
      wr(`UFC_A_EFR, j == 0 ? 8'h08 : (j == 1 ? 8'h04 : 8'h0c));
      for (int k = 0; k <= j / 2; k++) q_tx.push_back({24'h0, ch[2 + j % 2 + k] & `UFC_MASK_5});
      rx_level <= 7'd41;
      tick(30);
      for (int k = 0; k <= j / 2; k++) q_tx.push_back({24'h0, ch[j % 2 + k] & `UFC_MASK_5});
      rx_level <= 7'd12;
      tick(30);
    end
    rx_level <= 7'h00;
    // Software reset, then pin reset
    wr(`UFC_A_EFR, 8'h40);
    wr(`UFC_A_SWRST, 8'h01);
    tick(3);
    cmp(n_clr, 1);
    cmp(io_ctrl, 8'h00);
    cmp(line_ctrl, `UFC_RST_LCR);
    cmp(rts_n, 1'b1);
    cmp(rx_trig_level, `UFC_TRIG_OFF);
    for (int k = 0; k < 4; k++) rd(8'h08 + 8'(4 * k), k == 2 ? `UFC_RST_LCR : 32'h0);
    for (int k = 0; k < 3; k++) rd(8'h24 + 8'(4 * k), 32'h0);
    rd(`UFC_A_DIV_LO, {24'h0, ~sp});
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    rd(`UFC_A_SPR, {24'h0, sp});
    rd(`UFC_A_P1, {24'h0, ch[2]});
    rd(`UFC_A_LCR, `UFC_RST_LCR);
    tick(4);
    cmp({24'h0, divisor[7:0]}, {24'h0, ~sp});
    cmp(q_tx.size(), 0);
    cmp(q_rx.size(), 0);
    test_done();
  end
endmodule : testbench
